// File: sbf_pkg.sv
// Constants and state types for the buffered serial port block.
// Assumes one byte-wide register port and a single clk domain.
package sbf_pkg;
    localparam int AW = 3;
    localparam int DW = 8;
    // Register addresses
    localparam logic [AW-1:0] A_CTRLA = 3'h0;
    localparam logic [AW-1:0] A_CTRLB = 3'h1;
    localparam logic [AW-1:0] A_INTCTRL = 3'h2;
    localparam logic [AW-1:0] A_FLAGS = 3'h3;
    localparam logic [AW-1:0] A_DATA = 3'h4;
    localparam logic [AW-1:0] A_FLAGCLR = 3'h5;
    // Field positions
    localparam int B_EN = 0;
    localparam int B_PRESC = 1;
    localparam int B_CLK2X = 4;
    localparam int B_MASTER = 5;
    localparam int B_BUFOP = 7;
    localparam int B_SELDIS = 2;
    localparam int B_MODE = 0;
    localparam int B_RXC = 7;
    localparam int B_TXC = 6;
    localparam int B_DRE = 5;
    localparam int B_SS = 4;
    localparam int B_IE = 0;
    localparam int B_OVF = 0;
    localparam logic [DW-1:0] DATA_RST = 8'h00;
    // Half period of the generated clock, in clk cycles, per prescaler
    localparam logic [6:0] HALF_DIV4 = 7'h02;
    localparam logic [6:0] HALF_DIV16 = 7'h08;
    localparam logic [6:0] HALF_DIV64 = 7'h20;
    localparam logic [6:0] HALF_DIV128 = 7'h40;
    localparam logic [3:0] LAST_EDGE = 4'hf;
    localparam logic [3:0] LAST_SAMPLE = 4'h7;

    typedef enum logic {LINK_IDLE, LINK_SHIFT} sbf_link_t;

    typedef struct packed {
        logic en, master, clk2x;
        logic [1:0] presc;
        logic buffered_operation_enable, selDis;
        logic [1:0] mode;
        logic rxcie, txcie, txEmptyIe, ssie, ie;
        logic txcif, selFlag, ovfFlag, ifl, ovfPend, reload;
        logic txFull;
        logic [DW-1:0] txBuf, txSh, rxSh, rdata;
        sbf_link_t phase;
        logic [3:0] edgeCnt, sampCnt;
        logic [6:0] halfCnt;
        logic sckLvl, sckPrev, sdo, irq, sckOeN, misoOeN;
    } sbf_state_t;
endpackage

// File: sbf_rx_if.sv
// Receive buffer link between the port logic and its byte store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface sbf_rx_if #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
);
    localparam int CW = $clog2(DEPTH + 1);
    logic push;
    logic [WIDTH-1:0] pushData;
    logic pop;
    logic [WIDTH-1:0] head;
    logic [CW-1:0] count;
    modport producer (output push, pushData, pop, input head, count);
    modport store (input push, pushData, pop, output head, count);
endinterface

// File: sbf_sync.sv
// Two-stage synchroniser for pins from outside the clk domain.
// Assumes only the second stage is read by any logic.
`timescale 1ns/1ps
module sbf_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST = '0
)(
    input logic clk,
    input logic rstn,
    input logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1, s2;
    } sbf_sync_t;
    sbf_sync_t st_reg, st_next;

    // Stage one feeds stage two only
    always_comb
    begin
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            st_reg.s1 <= RST;
            st_reg.s2 <= RST;
        end
        else
            st_reg <= st_next;
    end

    assign q = st_reg.s2;
endmodule

// File: sbf_rx_fifo.sv
// Small receive store: oldest byte at the head, pop moves the rest up.
// Assumes the producer never pushes into a full store without a pop.
`timescale 1ns/1ps
module sbf_rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
)(
    input logic clk,
    input logic rstn,
    sbf_rx_if.store rx
);
    localparam int CW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] ent;
        logic [CW-1:0] cnt;
    } sbf_fifo_t;
    sbf_fifo_t st_reg, st_next;

    // Pop first so a pop and a push in one cycle both succeed
    always_comb
    begin
        st_next = st_reg;
        if (rx.pop && st_reg.cnt != '0)
        begin
            for (int i = 0; i < DEPTH - 1; i++)
                st_next.ent[i] = st_reg.ent[i+1];
            st_next.ent[DEPTH-1] = '0;
            st_next.cnt = st_reg.cnt - CW'(1);
        end
        if (rx.push && st_next.cnt < CW'(DEPTH))
        begin
            st_next.ent[st_next.cnt] = rx.pushData;
            st_next.cnt = st_next.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign rx.head = st_reg.ent[0];
    assign rx.count = st_reg.cnt;
endmodule

// File: sbf_spi.sv
// Serial port, master or slave, with buffered flags and data register.
// Assumes clk runs much faster than the link clock; pins are synchronised.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - Empty flag high while transmit buffer empty, low while byte waits.
// - Empty flag comes out of reset set.
// - Writing the data register clears the empty flag.
// - Enabled empty interrupt keeps requesting until written or disabled.
// - Without buffering the empty and select flags do nothing.
// - Buffered: select pulled low while master sets select flag, goes slave.
// - Select flag never sets while select-line-disable is one.
// - Writing one to the select flag clears it; zero leaves it.
// - Overrun sets when both entries full and a third byte arrives.
// - With no transmit data, overrun waits for the next transfer start.
// - Overrun stays until software reads the data register.
// - Writing the data register as an idle master starts shifting that byte out.
// - Reading data returns oldest byte and moves the rest forward.
// - Buffered mode: two receive entries, one transmit, separate flags.
// - With select-line-disable set, low select keeps master operation.
module sbf_spi #(
    parameter int RX_DEPTH = 2
)(
    input logic clk,
    input logic rstn,
    input logic [sbf_pkg::AW-1:0] regAddr,
    input logic [sbf_pkg::DW-1:0] regWdata,
    input logic regWr,
    input logic regRd,
    output logic [sbf_pkg::DW-1:0] regRdata,
    output logic irq,
    input logic sckIn,
    output logic sckOut,
    output logic sckOe_n,
    input logic mosiIn,
    output logic mosiOut,
    output logic mosiOe_n,
    input logic misoIn,
    output logic misoOut,
    output logic misoOe_n,
    input logic ssIn_n
);
    localparam int CW = $clog2(RX_DEPTH + 1);
    sbf_pkg::sbf_state_t st_reg, st_next;
    logic ssQ, sckQ, mosiQ, misoQ;
    logic dataWr, dataRd, flagsWr, clrWr, ssTrig, cpha, cpol, shifting;
    logic mstEdge, slvEdge, edgeNow, leading, sampleNow, setupNow, inBit;
    logic byteDone, rxFull, rxPush, rxPop, lostByte, slvSel, xferStart;
    logic [sbf_pkg::DW-1:0] rxNew;
    logic [6:0] halfSel;

    sbf_rx_if #(.WIDTH(sbf_pkg::DW), .DEPTH(RX_DEPTH)) rx ();

    sbf_sync #(.WIDTH(4), .RST(4'h8)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .d({ssIn_n, sckIn, mosiIn, misoIn}),
        .q({ssQ, sckQ, mosiQ, misoQ})
    );

    sbf_rx_fifo #(.WIDTH(sbf_pkg::DW), .DEPTH(RX_DEPTH)) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .rx(rx.store)
    );

    // Cheap helper: present bit 7 now, keep the rest for later edges
    function automatic logic [sbf_pkg::DW:0] present(
        input logic [sbf_pkg::DW-1:0] b);
        present = {b[sbf_pkg::DW-1], b[sbf_pkg::DW-2:0], 1'b0};
    endfunction

    // Bus decode
    assign dataWr = regWr && (regAddr == sbf_pkg::A_DATA);
    assign dataRd = regRd && (regAddr == sbf_pkg::A_DATA);
    assign flagsWr = regWr && (regAddr == sbf_pkg::A_FLAGS);
    assign clrWr = regWr && (regAddr == sbf_pkg::A_FLAGCLR);

    // Link edge detection; master edges come from the divider
    assign cpha = st_reg.mode[0];
    assign cpol = st_reg.mode[1];
    assign shifting = st_reg.phase == sbf_pkg::LINK_SHIFT;
    assign ssTrig = st_reg.en && st_reg.master && !ssQ && !st_reg.selDis;
    assign mstEdge = shifting && st_reg.master && (st_reg.halfCnt == '0);
    assign slvEdge = shifting && !st_reg.master && (sckQ != st_reg.sckPrev);
    assign edgeNow = mstEdge || slvEdge;
    assign leading = st_reg.master ? !st_reg.edgeCnt[0] : (sckQ != cpol);
    assign sampleNow = edgeNow && (leading ^ cpha);
    assign setupNow = edgeNow && !(leading ^ cpha);
    assign inBit = st_reg.master ? misoQ : mosiQ;
    assign rxNew = sampleNow ? {st_reg.rxSh[6:0], inBit} : st_reg.rxSh;
    assign byteDone = st_reg.master
        ? (mstEdge && st_reg.edgeCnt == sbf_pkg::LAST_EDGE)
        : (sampleNow && st_reg.sampCnt == sbf_pkg::LAST_SAMPLE);

    // Receive store handshake; a pop frees room for a same-cycle push
    assign rxFull = rx.count == CW'(RX_DEPTH);
    assign rxPop = dataRd && (rx.count != '0);
    assign rxPush = byteDone && (!rxFull || rxPop);
    assign lostByte = byteDone && !rxPush;
    assign rx.push = rxPush;
    assign rx.pushData = rxNew;
    assign rx.pop = rxPop;

    assign slvSel = st_reg.en && !st_reg.master && !ssQ;
    assign xferStart = !shifting && !ssTrig && st_reg.en
        && (st_reg.master ? st_reg.txFull : !ssQ);

    // Divider reload; double speed halves the half period
    always_comb
    begin
        unique case (st_reg.presc)
            2'h0: halfSel = sbf_pkg::HALF_DIV4;
            2'h1: halfSel = sbf_pkg::HALF_DIV16;
            2'h2: halfSel = sbf_pkg::HALF_DIV64;
            2'h3: halfSel = sbf_pkg::HALF_DIV128;
        endcase
        if (st_reg.clk2x)
            halfSel = halfSel >> 1;
        halfSel = halfSel - 7'h01;
    end

    // Whole next state; software clears come before hardware sets
    always_comb
    begin
        st_next = st_reg;
        st_next.sckPrev = sckQ;
        st_next.rdata = '0;
        if (regWr && regAddr == sbf_pkg::A_CTRLA)
        begin
            st_next.en = regWdata[sbf_pkg::B_EN];
            st_next.presc = regWdata[sbf_pkg::B_PRESC +: 2];
            st_next.clk2x = regWdata[sbf_pkg::B_CLK2X];
            st_next.master = regWdata[sbf_pkg::B_MASTER];
        end
        if (regWr && regAddr == sbf_pkg::A_CTRLB)
        begin
            st_next.buffered_operation_enable = regWdata[sbf_pkg::B_BUFOP];
            st_next.selDis = regWdata[sbf_pkg::B_SELDIS];
            st_next.mode = regWdata[sbf_pkg::B_MODE +: 2];
        end
        if (regWr && regAddr == sbf_pkg::A_INTCTRL)
        begin
            st_next.rxcie = regWdata[sbf_pkg::B_RXC];
            st_next.txcie = regWdata[sbf_pkg::B_TXC];
            st_next.txEmptyIe = regWdata[sbf_pkg::B_DRE];
            st_next.ssie = regWdata[sbf_pkg::B_SS];
            st_next.ie = regWdata[sbf_pkg::B_IE];
        end
        // Write-one-to-clear; the overrun position is ignored here
        if ((flagsWr || clrWr) && regWdata[sbf_pkg::B_TXC])
            st_next.txcif = 1'b0;
        if ((flagsWr || clrWr) && regWdata[sbf_pkg::B_SS])
            st_next.selFlag = 1'b0;
        // A data write fills the single transmit entry; unbuffered, only when idle and the entry is empty
        if (dataWr && (st_reg.buffered_operation_enable || (!shifting && !st_reg.txFull)))
        begin
            st_next.txBuf = regWdata;
            st_next.txFull = 1'b1;
        end
        if (dataRd)
            st_next.ovfFlag = 1'b0;
        if (dataRd || dataWr)
            st_next.ifl = 1'b0;

        // Link sequencing
        if (ssTrig)
        begin
            // Forced out of master; abort any byte in flight
            st_next.master = 1'b0;
            st_next.phase = sbf_pkg::LINK_IDLE;
            if (st_reg.buffered_operation_enable)
                st_next.selFlag = 1'b1;
            else
                st_next.ifl = 1'b1;
        end
        else if (xferStart)
        begin
            st_next.phase = sbf_pkg::LINK_SHIFT;
            st_next.edgeCnt = '0;
            st_next.sampCnt = '0;
            st_next.halfCnt = halfSel;
            st_next.sckLvl = cpol;
            st_next.reload = 1'b0;
            if (st_reg.txFull)
            begin
                st_next.txFull = dataWr && st_reg.buffered_operation_enable;
                {st_next.sdo, st_next.txSh} = present(st_reg.txBuf);
            end
            else
                {st_next.sdo, st_next.txSh} = '0;
            if (st_reg.ovfPend)
            begin
                st_next.ovfFlag = 1'b1;
                st_next.ovfPend = 1'b0;
            end
        end
        else if (shifting && !st_reg.master && ssQ)
            st_next.phase = sbf_pkg::LINK_IDLE;
        else if (shifting)
        begin
            if (st_reg.master)
            begin
                st_next.halfCnt = mstEdge ? halfSel
                    : st_reg.halfCnt - 7'h01;
                if (mstEdge)
                begin
                    st_next.sckLvl = !st_reg.sckLvl;
                    st_next.edgeCnt = st_reg.edgeCnt + 4'h1;
                end
            end
            if (sampleNow)
            begin
                st_next.rxSh = rxNew;
                st_next.sampCnt = st_reg.sampCnt + 4'h1;
                if (st_reg.sampCnt == '0 && st_reg.ovfPend)
                begin
                    st_next.ovfFlag = 1'b1;
                    st_next.ovfPend = 1'b0;
                end
            end
            // A slave reloads on the first setup edge after a byte
            if (setupNow && st_reg.reload)
            begin
                st_next.reload = 1'b0;
                if (st_reg.txFull)
                begin
                    {st_next.sdo, st_next.txSh} = present(st_reg.txBuf);
                    st_next.txFull = dataWr && st_reg.buffered_operation_enable;
                end
                else
                    {st_next.sdo, st_next.txSh} = '0;
            end
            else if (setupNow)
            begin
                st_next.sdo = st_reg.txSh[sbf_pkg::DW-1];
                st_next.txSh = {st_reg.txSh[sbf_pkg::DW-2:0], 1'b0};
            end
            if (byteDone)
            begin
                if (st_reg.master)
                begin
                    st_next.phase = sbf_pkg::LINK_IDLE;
                    st_next.sckLvl = cpol;
                end
                else
                begin
                    st_next.sampCnt = '0;
                    st_next.reload = 1'b1;
                end
                if (!st_reg.buffered_operation_enable)
                    st_next.ifl = 1'b1;
                else if (!st_reg.txFull)
                    st_next.txcif = 1'b1;
                // Third byte lost; flag now only if more data will go out
                if (lostByte && st_reg.buffered_operation_enable && st_reg.txFull)
                    st_next.ovfFlag = 1'b1;
                else if (lostByte && st_reg.buffered_operation_enable)
                    st_next.ovfPend = 1'b1;
            end
        end
        else if (st_reg.master)
            st_next.sckLvl = cpol;

        // Register reads; unmapped and write-only addresses give zero
        if (regRd)
        begin
            unique case (regAddr)
                sbf_pkg::A_CTRLA:
                begin
                    st_next.rdata[sbf_pkg::B_EN] = st_reg.en;
                    st_next.rdata[sbf_pkg::B_PRESC +: 2] = st_reg.presc;
                    st_next.rdata[sbf_pkg::B_CLK2X] = st_reg.clk2x;
                    st_next.rdata[sbf_pkg::B_MASTER] = st_reg.master;
                end
                sbf_pkg::A_CTRLB:
                begin
                    st_next.rdata[sbf_pkg::B_BUFOP] = st_reg.buffered_operation_enable;
                    st_next.rdata[sbf_pkg::B_SELDIS] = st_reg.selDis;
                    st_next.rdata[sbf_pkg::B_MODE +: 2] = st_reg.mode;
                end
                sbf_pkg::A_INTCTRL:
                begin
                    st_next.rdata[sbf_pkg::B_RXC] = st_reg.rxcie;
                    st_next.rdata[sbf_pkg::B_TXC] = st_reg.txcie;
                    st_next.rdata[sbf_pkg::B_DRE] = st_reg.txEmptyIe;
                    st_next.rdata[sbf_pkg::B_SS] = st_reg.ssie;
                    st_next.rdata[sbf_pkg::B_IE] = st_reg.ie;
                end
                sbf_pkg::A_FLAGS:
                begin
                    // Buffer-mode flags read as zero when unbuffered
                    if (st_reg.buffered_operation_enable)
                    begin
                        st_next.rdata[sbf_pkg::B_RXC] = rx.count != '0;
                        st_next.rdata[sbf_pkg::B_TXC] = st_reg.txcif;
                        st_next.rdata[sbf_pkg::B_DRE] = !st_reg.txFull;
                        st_next.rdata[sbf_pkg::B_SS] = st_reg.selFlag;
                        st_next.rdata[sbf_pkg::B_OVF] = st_reg.ovfFlag;
                    end
                    else
                        st_next.rdata[sbf_pkg::B_RXC] = st_reg.ifl;
                end
                sbf_pkg::A_DATA: st_next.rdata = rx.head;
                default: st_next.rdata = '0;
            endcase
        end

        // One level interrupt; unbuffered only the plain flag counts
        if (st_reg.buffered_operation_enable)
            st_next.irq = (st_reg.rxcie && rx.count != '0)
                || (st_reg.txcie && st_reg.txcif)
                || (st_reg.txEmptyIe && !st_reg.txFull)
                || (st_reg.ssie && st_reg.selFlag);
        else
            st_next.irq = st_reg.ie && st_reg.ifl;

        // Pin enables are registered so every output leaves a flop
        st_next.sckOeN = !(st_next.en && st_next.master);
        st_next.misoOeN = !(st_next.en && !st_next.master && !ssQ);
    end

    // Transmit entry empty after reset
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            st_reg <= '0;
            st_reg.sckOeN <= 1'b1;
            st_reg.misoOeN <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    assign regRdata = st_reg.rdata;
    assign irq = st_reg.irq;
    assign sckOut = st_reg.sckLvl;
    assign sckOe_n = st_reg.sckOeN;
    assign mosiOut = st_reg.sdo;
    assign mosiOe_n = st_reg.sckOeN;
    assign misoOut = st_reg.sdo;
    assign misoOe_n = st_reg.misoOeN;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_mstReady;
        st_reg.en && st_reg.master && st_reg.txFull
            && !shifting && !dataWr && !ssTrig;
    endsequence
    sequence s_forced;
        st_reg.en && st_reg.master && !st_reg.selDis && !ssQ && st_reg.buffered_operation_enable;
    endsequence
    sequence s_popFull;
        rxPop && rxFull && !rxPush;
    endsequence

    property p_dre_reset;
        $rose(rstn) |-> !st_reg.txFull;
    endproperty
    a_dre_reset: assert property (p_dre_reset)
        else $error("empty flag not set after reset");
    property p_dre_clear;
        dataWr && st_reg.buffered_operation_enable |=> st_reg.txFull || shifting;
    endproperty
    a_dre_clear: assert property (p_dre_clear)
        else $error("data write did not clear empty flag");
    property p_load;
        s_mstReady |=> shifting && !st_reg.txFull
            && st_reg.sdo == $past(st_reg.txBuf[sbf_pkg::DW-1]);
    endproperty
    a_load: assert property (p_load)
        else $error("pending byte not moved to shifter");
    property p_dre_irq;
        st_reg.buffered_operation_enable && st_reg.txEmptyIe && !st_reg.txFull |=> irq;
    endproperty
    a_dre_irq: assert property (p_dre_irq)
        else $error("empty interrupt not requested");
    property p_nobuf_quiet;
        !st_reg.buffered_operation_enable && !(st_reg.ie && st_reg.ifl) |=> !irq;
    endproperty
    a_nobuf_quiet: assert property (p_nobuf_quiet)
        else $error("buffer flags raised interrupt while unbuffered");
    property p_ss_trig;
        s_forced |=> st_reg.selFlag && !st_reg.master;
    endproperty
    a_ss_trig: assert property (p_ss_trig)
        else $error("select pulled low not flagged");
    property p_seldis_hold;
        st_reg.selDis && st_reg.master && !st_reg.selFlag && !regWr
            |=> !st_reg.selFlag && st_reg.master;
    endproperty
    a_seldis_hold: assert property (p_seldis_hold)
        else $error("select line acted while disabled");
    property p_ss_w1c;
        flagsWr && regWdata[sbf_pkg::B_SS] && !ssTrig |=> !st_reg.selFlag;
    endproperty
    a_ss_w1c: assert property (p_ss_w1c)
        else $error("select flag not cleared by write of one");
    property p_ovf_set;
        lostByte && st_reg.buffered_operation_enable && st_reg.txFull |=> st_reg.ovfFlag;
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overrun not flagged");
    property p_ovf_hold;
        st_reg.ovfFlag && !dataRd |=> st_reg.ovfFlag;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold)
        else $error("overrun flag dropped without data read");
    property p_pop;
        s_popFull |=> rx.count == CW'(RX_DEPTH - 1)
            && regRdata == $past(rx.head);
    endproperty
    a_pop: assert property (p_pop)
        else $error("data read did not return and advance oldest byte");
endmodule

// File: sbf_far_slave.sv
// Far-side slave model for the serial port, link mode 0, MSB first.
// Assumes it is always selected, so it drives its out line at all times.
`timescale 1ns/1ps
module sbf_far_slave #(
    parameter logic [7:0] FIRST = 8'h3c
)(
    input logic sck,
    input logic mosi,
    output logic miso,
    output logic [7:0] gotByte,
    output int frames
);
    logic [7:0] reply = FIRST;
    logic [7:0] shIn = 8'h00;
    logic [7:0] txSh = FIRST;
    int bits = 0;
    initial frames = 0;
    initial gotByte = 8'h00;
    assign miso = txSh[7];
    // Sample on the leading edge; each reply differs so order shows
    always @(posedge sck)
    begin
        shIn = {shIn[6:0], mosi};
        bits = (bits + 1) % 8;
        if (bits == 0)
        begin
            gotByte = shIn;
            frames++;
            reply++;
        end
    end
    // Setup on the trailing edge; the next reply's MSB waits in place
    always @(negedge sck)
        txSh = (bits == 0) ? reply : {txSh[6:0], 1'b0};
endmodule

// File: sbf_spi_tb.sv
// Testbench for the serial port block acting as buffered master.
// Assumes the far slave model answers on the link pins.
`timescale 1ns/1ps
module sbf_spi_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [sbf_pkg::AW-1:0] regAddr = 3'h0;
    logic [sbf_pkg::DW-1:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic ssIn_n = 1'b1;
    logic [7:0] regRdata, rv, gotByte;
    logic irq, sckOut, sckOe_n, mosiOut, mosiOe_n, misoOut, misoOe_n;
    logic sckW, mosiW, misoW;
    int frames;
    int n_errors = 0;
    int samples_checked = 0;
    // Released lines sit on a pull-down
    assign sckW = sckOe_n ? 1'b0 : sckOut;
    assign mosiW = mosiOe_n ? 1'b0 : mosiOut;
    always #10 clk = ~clk;
    sbf_spi i_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .irq(irq), .sckIn(sckW), .sckOut(sckOut),
        .sckOe_n(sckOe_n), .mosiIn(mosiW), .mosiOut(mosiOut),
        .mosiOe_n(mosiOe_n), .misoIn(misoW), .misoOut(misoOut),
        .misoOe_n(misoOe_n), .ssIn_n(ssIn_n));
    sbf_far_slave i_far (.sck(sckW), .mosi(mosiW), .miso(misoW),
        .gotByte(gotByte), .frames(frames));
    // Register bus cycles, one strobe cycle each
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 rv = regRdata;
    endtask
    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask
    // Bounded wait for the far side to see a whole byte, then let it land
    task automatic wait_frame(input int n);
        for (int i = 0; i < 300 && frames < n; i++)
            @(posedge clk);
        if (frames < n)
        begin
            n_errors++;
            $display("[FAIL] frames expected %0d seen %0d", n, frames);
        end
        repeat (4) @(posedge clk);
    endtask
    task automatic t_unbuffered;
        wr(sbf_pkg::A_INTCTRL, 8'h20);
        repeat (2) @(posedge clk);
        chk("irq", 8'h00, {7'h00, irq});
        rd(sbf_pkg::A_FLAGS);
        chk("flags", 8'h00, rv);
        rd(3'h7);
        chk("unmapped", 8'h00, rv);
    endtask
    task automatic t_empty_irq;
        wr(sbf_pkg::A_CTRLB, 8'h80);
        rd(sbf_pkg::A_FLAGS);
        chk("flags", 8'h20, rv);
        chk("irq", 8'h01, {7'h00, irq});
        wr(sbf_pkg::A_INTCTRL, 8'h00);
        repeat (2) @(posedge clk);
        chk("irq", 8'h00, {7'h00, irq});
    endtask
    // Link clock at 160 ns: prescale 16 doubled; third byte is dropped
    task automatic t_stream;
        wr(sbf_pkg::A_CTRLA, 8'h33);
        wr(sbf_pkg::A_DATA, 8'ha5);
        wr(sbf_pkg::A_DATA, 8'h5a);
        rd(sbf_pkg::A_FLAGS);
        chk("flags", 8'h00, rv & 8'h21);
        wait_frame(1);
        chk("link", 8'ha5, gotByte);
        chk("mosioe", 8'h00, {7'h00, mosiOe_n});
        wait_frame(2);
        chk("link", 8'h5a, gotByte);
        rd(sbf_pkg::A_FLAGS);
        chk("flags", 8'ha0, rv & 8'ha1);
        wr(sbf_pkg::A_DATA, 8'h11);
        wait_frame(3);
        rd(sbf_pkg::A_FLAGS);
        chk("flags", 8'h00, rv & 8'h01);
        wr(sbf_pkg::A_DATA, 8'h22);
        repeat (3) @(posedge clk);
        rd(sbf_pkg::A_FLAGS);
        chk("flags", 8'h01, rv & 8'h01);
        rd(sbf_pkg::A_DATA);
        chk("data", 8'h3c, rv);
        rd(sbf_pkg::A_FLAGS);
        chk("flags", 8'h00, rv & 8'h01);
        wait_frame(4);
        rd(sbf_pkg::A_DATA);
        chk("data", 8'h3d, rv);
        rd(sbf_pkg::A_DATA);
        chk("data", 8'h3f, rv);
    endtask
    task automatic t_select;
        wr(sbf_pkg::A_CTRLB, 8'h84);
        ssIn_n <= 1'b0;
        repeat (6) @(posedge clk);
        rd(sbf_pkg::A_FLAGS);
        chk("flags", 8'h00, rv & 8'h10);
        rd(sbf_pkg::A_CTRLA);
        chk("ctrla", 8'h33, rv);
        ssIn_n <= 1'b1;
        wr(sbf_pkg::A_CTRLB, 8'h80);
        repeat (4) @(posedge clk);
        ssIn_n <= 1'b0;
        repeat (6) @(posedge clk);
        rd(sbf_pkg::A_FLAGS);
        chk("flags", 8'h10, rv & 8'h10);
        chk("sckoe", 8'h01, {7'h00, sckOe_n});
        chk("misooe", 8'h00, {7'h00, misoOe_n});
        wr(sbf_pkg::A_FLAGS, 8'h00);
        rd(sbf_pkg::A_FLAGS);
        chk("flags", 8'h10, rv & 8'h10);
        wr(sbf_pkg::A_FLAGS, 8'h10);
        rd(sbf_pkg::A_FLAGS);
        chk("flags", 8'h00, rv & 8'h10);
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_unbuffered();
        t_empty_irq();
        t_stream();
        t_select();
        print_verdict();
    end
    // Whole run needs well under 1000 cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
endmodule
